// File: rtl/buck_fault_ctrl.sv
// dual-channel buck hiccup, soft-start, standby and dead-time supervisor
//
// Summary of operation
// - 512 limited cycles: discharge soft-start, gates off
// - retry node charges; threshold discharges, releases soft-start
// - four clean cycles clear the hiccup counter
// - per-channel counters, one shared retry node
// - last expiring channel restarts charge; joint restart
// - retry node tied high at power-up disables hiccup
// - forced-PWM clamps soft-start 200 mV over feedback
// - diode emulation clamps after 32 limit events
// - 16 missing cycles enter low-current standby
// - standby only in diode emulation
// - feedback follows lower of soft-start or reference
// - external soft-start low pulls comp; PWM keeps low side
// - fault soft-start discharge disables low-side gate
// - diode emulation: reverse current turns low side off
// - low side waits for top gate below threshold
// - top side waits for bottom gate below threshold
// - current limit ends the top pulse, one event
`timescale 1ns/1ps
`include "buck_fault_map.svh"
module buck_fault_ctrl #(
    parameter logic [7:0] SW_DIV = 8'(`SW_DIV),
    parameter logic [3:0] DT_CYC = 4'(`DT_CYC)
) (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        retry_thr_i,
    input  wire logic        retry_tied_rail_i,
    input  wire logic        conduction_mode_select_i,
    input  wire logic [1:0]  cur_limit_i,
    input  wire logic [1:0]  rev_current_i,
    input  wire logic [1:0]  top_gate_low_i,
    input  wire logic [1:0]  bottom_gate_low_i,
    input  wire logic [1:0]  ss_ext_low_i,
    input  wire logic [1:0]  ss_below_ref_i,
    input  wire logic [1:0]  pwm_req_i,
    output logic [1:0]       top_switch_gate_o,
    output logic [1:0]       bottom_switch_gate_o,
    output logic [1:0]       ss_discharge_o,
    output logic [1:0]       ss_clamp_o,
    output logic [1:0]       comp_pull_low_o,
    output logic [1:0]       ss_ref_select_o,
    output logic [1:0]       standby_o,
    output logic             retry_delay_pin_discharge_o,
    output logic             irq_o
);

    buck_fault_pkg::state_t s_r;
    buck_fault_pkg::state_t s_nxt;
    logic [`PIN_W-1:0]      pins;

    // ****************************************************************
    // pin vector assembly
    // ****************************************************************
    assign pins[`PIN_RTHR]  = retry_thr_i;
    assign pins[`PIN_RTIED] = retry_tied_rail_i;
    assign pins[`PIN_MODE]  = conduction_mode_select_i;

    for (genvar g = 0; g < 2; g++) begin : g_pins
        localparam int B = `PIN_CH_BASE + g * `PIN_CH_W;
        assign pins[B + `PIN_CL]    = cur_limit_i[g];
        assign pins[B + `PIN_REV]   = rev_current_i[g];
        assign pins[B + `PIN_HOLOW] = top_gate_low_i[g];
        assign pins[B + `PIN_LOLOW] = bottom_gate_low_i[g];
        assign pins[B + `PIN_SSEXT] = ss_ext_low_i[g];
        assign pins[B + `PIN_SSREF] = ss_below_ref_i[g];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic                     forced_pwm_mode;
        logic                     release_all;
        logic                     any_entry;
        logic                     want_hs;
        logic                     want_ls;
        logic                     rd_ok;
        logic                     wr_ok;
        logic [`IRQ_W-1:0]        ev;
        logic [`IRQ_W-1:0]        clr;
        logic [`PIN_CH_W-1:0]     cp;
        logic [9:0]               cnt_inc;
        s_nxt       = s_r;
        ev          = '0;
        clr         = '0;
        any_entry   = 1'b0;
        want_hs     = 1'b0;
        want_ls     = 1'b0;
        cp          = '0;
        cnt_inc     = '0;
        forced_pwm_mode        = 1'b0;
        release_all = 1'b0;
        rd_ok       = 1'b0;
        wr_ok       = 1'b0;

        // 3-stage sync, a change counts once stages 2 and 3 agree
        s_nxt.s1 = pins;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int b = 0; b < `PIN_W; b++) begin
            if (s_r.s2[b] == s_r.s3[b]) begin
                s_nxt.filt[b] = s_r.s3[b];
            end
        end
        forced_pwm_mode = s_r.filt[`PIN_MODE];

        // switching-cycle enable
        s_nxt.tick = 1'b0;
        if (s_r.div >= SW_DIV - 8'h01) begin
            s_nxt.div  = 8'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 8'h01;
        end

        // strap caught once the sync pipe has filled
        if (!s_r.strap_done) begin
            if (s_r.strap_cnt == `STRAP_WAIT) begin
                s_nxt.strap_done = 1'b1;
                // filt itself lands one cycle after this count ends
                s_nxt.hic_dis    = s_nxt.filt[`PIN_RTIED];
            end else begin
                s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
            end
        end

        release_all = (s_r.retry == buck_fault_pkg::R_CHARGE) &&
                      s_r.filt[`PIN_RTHR];

        for (int c = 0; c < 2; c++) begin
            cp = s_r.filt[`PIN_CH_BASE + c * `PIN_CH_W +: `PIN_CH_W];
            // a limit trip blanks the top pulse for the rest of the cycle
            if (cp[`PIN_CL]) begin
                s_nxt.ch[c].cl_seen = 1'b1;
            end
            if (pwm_req_i[c]) begin
                s_nxt.ch[c].req_seen = 1'b1;
            end
            if (s_r.tick) begin
                s_nxt.ch[c].cl_seen  = cp[`PIN_CL];
                s_nxt.ch[c].req_seen = pwm_req_i[c];
                if (!s_r.ch[c].hiccup) begin
                    if (s_r.ch[c].cl_seen) begin
                        cnt_inc = s_r.ch[c].cnt + 10'h001;
                        s_nxt.ch[c].cnt    = cnt_inc;
                        s_nxt.ch[c].ok_run = 3'h0;
                        if (cnt_inc == `HIC_LIMIT && s_r.strap_done &&
                            !s_r.hic_dis) begin
                            s_nxt.ch[c].hiccup = 1'b1;
                            ev[`IRQ_HIC0 + c]  = 1'b1;
                            any_entry          = 1'b1;
                        end
                    end else if (s_r.ch[c].ok_run + 3'h1 >= `OK_RUN_CLEAR)
                    begin
                        s_nxt.ch[c].cnt    = 10'h000;
                        s_nxt.ch[c].ok_run = `OK_RUN_CLEAR;
                    end else begin
                        s_nxt.ch[c].ok_run = s_r.ch[c].ok_run + 3'h1;
                    end
                end
                // missing-cycle tracking
                if (s_r.ch[c].req_seen) begin
                    s_nxt.ch[c].miss    = 5'h00;
                    s_nxt.ch[c].standby = 1'b0;
                end else if (s_r.ch[c].miss != `MISS_LIMIT) begin
                    s_nxt.ch[c].miss = s_r.ch[c].miss + 5'h01;
                end
            end
            if (s_nxt.ch[c].miss == `MISS_LIMIT && !forced_pwm_mode &&
                !s_r.ch[c].standby) begin
                s_nxt.ch[c].standby = 1'b1;
                ev[`IRQ_STB0 + c]   = 1'b1;
            end
            if (forced_pwm_mode || pwm_req_i[c]) begin
                s_nxt.ch[c].standby = 1'b0;
            end
            if (release_all && s_r.ch[c].hiccup) begin
                s_nxt.ch[c].hiccup = 1'b0;
                s_nxt.ch[c].cnt    = 10'h000;
                s_nxt.ch[c].ok_run = 3'h0;
            end
            s_nxt.ch[c].clamp = forced_pwm_mode ||
                                (s_nxt.ch[c].cnt >= `CLAMP_LIMIT);
            s_nxt.ch[c].comp_low = cp[`PIN_SSEXT];
            s_nxt.ch[c].ref_ss   = cp[`PIN_SSREF];

            // gate demand after fault, blanking and mode effects
            want_hs = pwm_req_i[c] && !s_nxt.ch[c].cl_seen &&
                      !cp[`PIN_CL] && !s_nxt.ch[c].hiccup &&
                      !cp[`PIN_SSEXT] && !s_nxt.ch[c].standby &&
                      s_r.ctrl_en;
            want_ls = !want_hs && !s_nxt.ch[c].hiccup &&
                      !s_nxt.ch[c].standby && s_r.ctrl_en &&
                      (forced_pwm_mode || !cp[`PIN_REV]);
            if (cp[`PIN_SSEXT] && forced_pwm_mode && s_r.ctrl_en &&
                !s_nxt.ch[c].hiccup) begin
                want_ls = 1'b1;
            end

            unique case (s_r.ch[c].gst)
                buck_fault_pkg::G_OFF: begin
                    s_nxt.ch[c].dly = 4'h0;
                    if (want_hs) begin
                        s_nxt.ch[c].gst = buck_fault_pkg::G_TO_HS;
                    end else if (want_ls) begin
                        s_nxt.ch[c].gst = buck_fault_pkg::G_TO_LS;
                    end
                end
                buck_fault_pkg::G_HS: begin
                    if (!want_hs) begin
                        s_nxt.ch[c].dly = 4'h0;
                        s_nxt.ch[c].gst = want_ls ?
                            buck_fault_pkg::G_TO_LS :
                            buck_fault_pkg::G_OFF;
                    end
                end
                buck_fault_pkg::G_LS: begin
                    if (!want_ls || want_hs) begin
                        s_nxt.ch[c].dly = 4'h0;
                        s_nxt.ch[c].gst = want_hs ?
                            buck_fault_pkg::G_TO_HS :
                            buck_fault_pkg::G_OFF;
                    end
                end
                buck_fault_pkg::G_TO_HS: begin
                    if (!want_hs) begin
                        s_nxt.ch[c].gst = buck_fault_pkg::G_OFF;
                    end else if (s_r.ch[c].dly < `GATE_SETTLE) begin
                        // a short bottom pulse never reaches filt
                        s_nxt.ch[c].dly = s_r.ch[c].dly + 4'h1;
                    end else if (cp[`PIN_LOLOW]) begin
                        if (s_r.ch[c].dly >=
                            `GATE_SETTLE + DT_CYC - 4'h1) begin
                            s_nxt.ch[c].gst = buck_fault_pkg::G_HS;
                        end else begin
                            s_nxt.ch[c].dly = s_r.ch[c].dly + 4'h1;
                        end
                    end
                end
                buck_fault_pkg::G_TO_LS: begin
                    if (!want_ls) begin
                        s_nxt.ch[c].gst = buck_fault_pkg::G_OFF;
                    end else if (s_r.ch[c].dly < `GATE_SETTLE) begin
                        // dead time above 12 cycles would wrap the count
                        s_nxt.ch[c].dly = s_r.ch[c].dly + 4'h1;
                    end else if (cp[`PIN_HOLOW]) begin
                        if (s_r.ch[c].dly >=
                            `GATE_SETTLE + DT_CYC - 4'h1) begin
                            s_nxt.ch[c].gst = buck_fault_pkg::G_LS;
                        end else begin
                            s_nxt.ch[c].dly = s_r.ch[c].dly + 4'h1;
                        end
                    end
                end
                default: begin
                    s_nxt.ch[c].gst = buck_fault_pkg::G_OFF;
                end
            endcase
            // gate flops follow the next state so they never overlap
            s_nxt.ch[c].hs = (s_nxt.ch[c].gst == buck_fault_pkg::G_HS);
            s_nxt.ch[c].ls = (s_nxt.ch[c].gst == buck_fault_pkg::G_LS);
        end

        // shared retry node
        unique case (s_r.retry)
            buck_fault_pkg::R_IDLE: begin
                if (any_entry) begin
                    s_nxt.retry = buck_fault_pkg::R_DUMP;
                end
            end
            buck_fault_pkg::R_DUMP: begin
                // wait for the node to read low, else a stale level releases
                if (!s_r.filt[`PIN_RTHR] && !any_entry) begin
                    s_nxt.retry = buck_fault_pkg::R_CHARGE;
                end
            end
            buck_fault_pkg::R_CHARGE: begin
                if (any_entry) begin
                    s_nxt.retry = buck_fault_pkg::R_DUMP;
                end else if (release_all) begin
                    s_nxt.retry = buck_fault_pkg::R_IDLE;
                    ev[`IRQ_RETRY] = 1'b1;
                end
            end
            default: begin
                s_nxt.retry = buck_fault_pkg::R_IDLE;
            end
        endcase
        s_nxt.retry_dis = (s_nxt.retry != buck_fault_pkg::R_CHARGE);

        // ****************************************************************
        // AHB-Lite slave, zero wait states
        // ****************************************************************
        rd_ok = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
        wr_ok = hsel_i && htrans_i[1] && hready_i && hwrite_i;
        s_nxt.wr_pend = wr_ok;
        s_nxt.wr_addr = haddr_i[7:0];
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                `REG_CTRL:     s_nxt.ctrl_en  = hwdata_i[0];
                `REG_IRQ_STAT: clr            = hwdata_i[`IRQ_W-1:0];
                `REG_IRQ_MASK: s_nxt.irq_mask = hwdata_i[`IRQ_W-1:0];
                default:       s_nxt.ctrl_en  = s_r.ctrl_en;
            endcase
        end
        // a new event wins over a clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
        s_nxt.hrdata   = 32'h0000_0000;
        if (rd_ok) begin
            unique case (haddr_i[7:0])
                `REG_CTRL:     s_nxt.hrdata = {31'h0, s_r.ctrl_en};
                `REG_STATUS:   s_nxt.hrdata = {21'h0, forced_pwm_mode, s_r.hic_dis,
                    s_r.retry == buck_fault_pkg::R_CHARGE,
                    s_r.ch[1].clamp, s_r.ch[0].clamp,
                    s_r.ch[1].standby, s_r.ch[0].standby,
                    s_r.ch[1].hiccup, s_r.ch[0].hiccup,
                    s_r.ch[1].ls, s_r.ch[0].ls};
                `REG_IRQ_STAT: s_nxt.hrdata = {27'h0, s_r.irq_stat};
                `REG_IRQ_MASK: s_nxt.hrdata = {27'h0, s_r.irq_mask};
                `REG_CNT0:     s_nxt.hrdata = {22'h0, s_r.ch[0].cnt};
                `REG_CNT1:     s_nxt.hrdata = {22'h0, s_r.ch[1].cnt};
                default:       s_nxt.hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_r           <= '0;
            s_r.retry_dis <= 1'b1;
            s_r.ctrl_en   <= `CTRL_RST;
            s_r.irq_stat  <= `IRQ_RST;
            s_r.irq_mask  <= `IRQ_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout_o                 = 1'b1;
    assign hresp_o                     = 1'b0;
    assign hrdata_o                    = s_r.hrdata;
    assign irq_o                       = s_r.irq;
    assign retry_delay_pin_discharge_o = s_r.retry_dis;
    for (genvar g = 0; g < 2; g++) begin : g_out
        assign top_switch_gate_o[g]    = s_r.ch[g].hs;
        assign bottom_switch_gate_o[g] = s_r.ch[g].ls;
        assign ss_discharge_o[g]       = s_r.ch[g].hiccup;
        assign ss_clamp_o[g]           = s_r.ch[g].clamp;
        assign comp_pull_low_o[g]      = s_r.ch[g].comp_low;
        assign ss_ref_select_o[g]      = s_r.ch[g].ref_ss;
        assign standby_o[g]            = s_r.ch[g].standby;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_gates_never_both: assert property (
        (top_switch_gate_o & bottom_switch_gate_o) == 2'b00)
        else $error("top and bottom gate on together");
    a_hiccup_gates_off: assert property (
        (ss_discharge_o & (top_switch_gate_o | bottom_switch_gate_o))
        == 2'b00)
        else $error("gate driven during hiccup");
    a_hiccup_entry: assert property (
        $rose(ss_discharge_o[0]) |-> $past(s_r.ch[0].cnt) == `HIC_LAST)
        else $error("hiccup entered at wrong count");
    a_retry_release: assert property (
        $fell(ss_discharge_o[0]) |->
        $past(s_r.retry) == buck_fault_pkg::R_CHARGE &&
        $past(s_r.filt[`PIN_RTHR]))
        else $error("hiccup left without retry threshold");
    a_hiccup_disabled: assert property (
        s_r.hic_dis |-> ss_discharge_o == 2'b00)
        else $error("hiccup while disabled by strap");
    a_clamp_in_pwm: assert property (
        s_r.filt[`PIN_MODE] |=> ss_clamp_o == 2'b11)
        else $error("soft-start not clamped in forced PWM");
    a_standby_count: assert property (
        $rose(standby_o[0]) |-> $past(s_r.ch[0].miss) == `MISS_LAST ||
        $past(s_r.ch[0].miss) == `MISS_LIMIT)
        else $error("standby entered early");
    a_standby_mode: assert property (
        (standby_o != 2'b00) |-> !$past(s_r.filt[`PIN_MODE]))
        else $error("standby in forced PWM");
    a_reverse_cut: assert property (
        s_r.filt[`PIN_CH_BASE + `PIN_REV] && !s_r.filt[`PIN_MODE]
        |=> !bottom_switch_gate_o[0])
        else $error("low side on with reverse current");
    a_dead_time: assert property (
        $rose(top_switch_gate_o[0]) |->
        !$past(bottom_switch_gate_o[0], 2))
        else $error("no dead time before top gate");

    c_hiccup_both: cover property (ss_discharge_o == 2'b11);
    c_retry_done: cover property ($fell(ss_discharge_o[0]));
    c_standby: cover property ($rose(standby_o[0]));
    c_irq: cover property ($rose(irq_o));

endmodule

// File: rtl/buck_fault_map.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef BUCK_FAULT_MAP_SVH
`define BUCK_FAULT_MAP_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ       100
`define CLK_NS        10
`define SW_KHZ        440
`define SW_DIV        ((`CLK_MHZ * 1000) / `SW_KHZ)
`define DT_NS         20
`define DT_CYC        ((`DT_NS + `CLK_NS - 1) / `CLK_NS)

// ****************************************************************
// event counts
// ****************************************************************
`define HIC_LIMIT     10'h200
`define HIC_LAST      10'h1FF
`define CLAMP_LIMIT   10'h020
`define OK_RUN_CLEAR  3'h4
`define MISS_LIMIT    5'h10
`define MISS_LAST     5'h0F
`define STRAP_WAIT    2'h3
// sync pipe depth plus one: a gate comparator read sooner is stale
`define GATE_SETTLE   4'h4

// ****************************************************************
// synchronised pin vector layout
// ****************************************************************
`define PIN_W         15
`define PIN_RTHR      0
`define PIN_RTIED     1
`define PIN_MODE      2
`define PIN_CH_BASE   3
`define PIN_CH_W      6
`define PIN_CL        0
`define PIN_REV       1
`define PIN_HOLOW     2
`define PIN_LOLOW     3
`define PIN_SSEXT     4
`define PIN_SSREF     5

// ****************************************************************
// register map (byte addresses) and fields
// ****************************************************************
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_IRQ_STAT  8'h08
`define REG_IRQ_MASK  8'h0C
`define REG_CNT0      8'h10
`define REG_CNT1      8'h14
`define CTRL_RST      1'h1
`define IRQ_W         5
`define IRQ_RST       5'h00
`define IRQ_HIC0      0
`define IRQ_HIC1      1
`define IRQ_RETRY     2
`define IRQ_STB0      3
`define IRQ_STB1      4

`endif

// File: rtl/buck_fault_pkg.sv
// types of the dual-channel buck fault and mode supervisor
`include "buck_fault_map.svh"
package buck_fault_pkg;

    typedef enum logic [2:0] {
        G_OFF   = 3'b000,
        G_TO_HS = 3'b001,
        G_HS    = 3'b010,
        G_TO_LS = 3'b011,
        G_LS    = 3'b100
    } gate_st_t;

    typedef enum logic [1:0] {
        R_IDLE   = 2'b00,
        R_DUMP   = 2'b01,
        R_CHARGE = 2'b10
    } retry_st_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic [2:0] ok_run;
        logic       cl_seen;
        logic       req_seen;
        logic [4:0] miss;
        logic       hiccup;
        logic       standby;
        logic       clamp;
        gate_st_t   gst;
        logic [3:0] dly;
        logic       hs;
        logic       ls;
        logic       comp_low;
        logic       ref_ss;
    } chan_t;

    typedef struct packed {
        logic [`PIN_W-1:0]  s1;
        logic [`PIN_W-1:0]  s2;
        logic [`PIN_W-1:0]  s3;
        logic [`PIN_W-1:0]  filt;
        chan_t [1:0]        ch;
        retry_st_t          retry;
        logic               retry_dis;
        logic [1:0]         strap_cnt;
        logic               strap_done;
        logic               hic_dis;
        logic               ctrl_en;
        logic [`IRQ_W-1:0]  irq_stat;
        logic [`IRQ_W-1:0]  irq_mask;
        logic               irq;
        logic [7:0]         div;
        logic               tick;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        hrdata;
    } state_t;

endpackage

// File: sim/buck_fault_ctrl_tb.sv
// self-checking bench of the buck fault and mode supervisor
`timescale 1ns/1ps
module buck_fault_ctrl_tb;
    logic        clk_sys_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic [1:0]  htrans    = 2'h0;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic        thr       = 1'b0;
    logic        mode      = 1'b0;
    logic        pwm0      = 1'b0;
    logic [1:0]  cl        = 2'h0;
    logic [1:0]  rev       = 2'h0;
    logic [1:0]  ssx       = 2'h0;
    logic [1:0]  cpl, sref;
    logic [31:0] hrdata, rd;
    logic [1:0]  tlow, blow, top, bot, dis, clamp, stb;
    logic        hready, rdis, irq;
    int          n_errors  = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    int          i;
    logic [7:0]  ra [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [31:0] rx [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

    buck_fault_ctrl #(.SW_DIV(8'h08), .DT_CYC(4'h2)) u_dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata),
        .retry_thr_i(thr), .retry_tied_rail_i(1'b0),
        .conduction_mode_select_i(mode), .cur_limit_i(cl),
        .rev_current_i(rev), .top_gate_low_i(tlow),
        .bottom_gate_low_i(blow), .ss_ext_low_i(ssx),
        .ss_below_ref_i(ssx), .pwm_req_i({cyc[3], pwm0}),
        .top_switch_gate_o(top), .bottom_switch_gate_o(bot),
        .ss_discharge_o(dis), .ss_clamp_o(clamp), .comp_pull_low_o(cpl),
        .ss_ref_select_o(sref), .standby_o(stb),
        .retry_delay_pin_discharge_o(rdis), .irq_o(irq));

    power_stage_model u_stage (.clk_sys_i(clk_sys_i), .top_gate_i(top),
        .bottom_gate_i(bot), .top_low_o(tlow), .bottom_low_o(blow));

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // called right after a rising edge; holds each phase until hready
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (!srst_i) chk({30'h0, top & bot}, 32'h0);
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // stimulus and checks
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (i = 0; i < 5; i++) begin
            ahb(1'b0, ra[i], 32'h0);
            chk(rd, rx[i]);
        end
        repeat (200) @(posedge clk_sys_i);
        chk({30'h0, stb}, 32'h1);
        rev <= 2'h2;
        repeat (6) @(posedge clk_sys_i);
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            chk({31'h0, bot[1]}, 32'h0);
        end
        rev <= 2'h0;
        cl <= 2'h1;
        repeat (300) @(posedge clk_sys_i);
        chk({30'h0, clamp}, 32'h1);
        ahb(1'b1, 8'h0C, 32'h1);
        for (i = 0; i < 6000 && dis[0] !== 1'b1; i++) @(posedge clk_sys_i);
        chk({28'h0, dis, top[0], bot[0]}, 32'h4);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq}, 32'h1);
        cl <= 2'h0;
        for (i = 0; i < 20 && rdis !== 1'b0; i++) @(posedge clk_sys_i);
        chk({31'h0, rdis}, 32'h0);
        thr <= 1'b1;
        for (i = 0; i < 20 && dis[0] !== 1'b0; i++) @(posedge clk_sys_i);
        chk({29'h0, dis, rdis}, 32'h1);
        thr <= 1'b0;
        ahb(1'b1, 8'h08, 32'h1F);
        @(posedge clk_sys_i);
        chk({31'h0, irq}, 32'h0);
        mode <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        chk({28'h0, clamp, stb}, 32'hC);
        ssx <= 2'h1;
        repeat (10) @(posedge clk_sys_i);
        chk({26'h0, cpl, sref, top[0], bot[0]}, 32'h15);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk({27'h0, rdis, top, bot}, 32'h10);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule

// File: sim/power_stage_model.sv
// power stage stand-in: gate voltage comparators of both channels
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic       clk_sys_i,
    input  wire logic [1:0] top_gate_i,
    input  wire logic [1:0] bottom_gate_i,
    output logic [1:0]      top_low_o,
    output logic [1:0]      bottom_low_o
);
    // gate charge takes a cycle to drain, so low is never seen at once
    always @(posedge clk_sys_i) begin
        top_low_o    <= ~top_gate_i;
        bottom_low_o <= ~bottom_gate_i;
    end
endmodule
